// ===== hw/pei_top.sv
// Function
// - only payload bits on transmit are corrupted, frame-wide or per channel
// - any subset of timeslots, including all, may be chosen
// - the last bit of each counted interval is inverted
// - framing bits are not counted and never inverted
// - a new rate takes effect only at a frame boundary
// - rate code 0 off, 1 is 1 in 16, each step doubles
// - rate code zero produces no errors even in constant mode
// - constant mode with nonzero rate ignores count, inserts forever
// - counted mode inserts exactly the programmed number then stops
// - count loads two cycles after the load bit rises zero to one
// - requested count is 10 bits over low and high registers
// - remaining count readable anytime over two registers, zero when done
`timescale 1ns/100ps
module pei_top
  import pei_pkg::*;
#(
  parameter int FIFO_DEPTH = PEI_FIFO_DEPTH
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic       tx_data,
  input  wire logic       tx_fbit,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic            out_data,
  output logic            out_fbit
);
  initial begin
    if (FIFO_DEPTH < 2) $error("fifo depth too small");
  end

  logic [7:0]  ctrl_r;
  logic [7:0]  cnt_lo_r;
  logic [1:0]  cnt_hi_r;
  logic [23:0] chmask_r;
  logic [7:0]  rdata_r;
  logic        load_prev_r;
  logic        load_pend_r;
  logic [9:0]  left_r;
  logic [9:0]  left_nxt;
  logic [3:0]  rate_act_r;
  logic        const_act_r;
  logic [2:0]  bit_idx_r;
  logic [4:0]  chan_r;

  // register decode
  wire wr_ctrl  = ce && reg_wr && (reg_addr == PEI_ADDR_CTRL);
  wire wr_lo    = ce && reg_wr && (reg_addr == PEI_ADDR_CNT_LO);
  wire wr_hi    = ce && reg_wr && (reg_addr == PEI_ADDR_CNT_HI);
  wire wr_m0    = ce && reg_wr && (reg_addr == PEI_ADDR_CHMASK0);
  wire wr_m1    = ce && reg_wr && (reg_addr == PEI_ADDR_CHMASK1);
  wire wr_m2    = ce && reg_wr && (reg_addr == PEI_ADDR_CHMASK2);
  wire load_bit = ctrl_r[PEI_CTRL_LOAD];
  wire load_rise = load_bit && !load_prev_r;

  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      PEI_ADDR_CTRL:    rd_mux = ctrl_r;
      PEI_ADDR_CNT_LO:  rd_mux = cnt_lo_r;
      PEI_ADDR_CNT_HI:  rd_mux = {6'h00, cnt_hi_r};
      PEI_ADDR_LEFT_LO: rd_mux = left_r[7:0];
      PEI_ADDR_LEFT_HI: rd_mux = {6'h00, left_r[9:8]};
      PEI_ADDR_CHMASK0: rd_mux = chmask_r[7:0];
      PEI_ADDR_CHMASK1: rd_mux = chmask_r[15:8];
      PEI_ADDR_CHMASK2: rd_mux = chmask_r[23:16];
      default:          rd_mux = 8'h00;
    endcase
  end
  assign reg_rdata = rdata_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= PEI_RST_BYTE;
    end else if (ce) begin
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // host registers, zero after reset except the channel mask, which resets to all ones
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_r   <= PEI_RST_BYTE;
      cnt_lo_r <= PEI_RST_BYTE;
      cnt_hi_r <= 2'h0;
      chmask_r <= PEI_RST_CHMASK;
    end else begin
      // bits 5 and 6 are kept at zero whatever the host writes
      if (wr_ctrl) ctrl_r   <= reg_wdata & PEI_CTRL_WMASK;
      if (wr_lo)   cnt_lo_r <= reg_wdata;
      if (wr_hi)   cnt_hi_r <= reg_wdata[1:0];
      if (wr_m0)   chmask_r[7:0]   <= reg_wdata;
      if (wr_m1)   chmask_r[15:8]  <= reg_wdata;
      if (wr_m2)   chmask_r[23:16] <= reg_wdata;
    end
  end

  // input side goes through the fifo
  logic fifo_valid;
  logic fifo_ready;
  logic fifo_data;
  logic fifo_fbit;
  pei_fifo #(
    .WIDTH (2),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .ce        (ce),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   ({tx_fbit, tx_data}),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  ({fifo_fbit, fifo_data})
  );

  // output stage register, stalls fifo when held
  logic out_valid_r;
  logic out_data_r;
  logic out_fbit_r;
  wire  stage_free = !out_valid_r || out_ready;
  assign fifo_ready = stage_free;
  wire  bit_move   = ce && fifo_valid && stage_free;
  assign out_valid = out_valid_r;
  assign out_data  = out_data_r;
  assign out_fbit  = out_fbit_r;

  // frame position: fbit starts a frame, 8 bits per channel
  wire chan_sel   = chmask_r[chan_r];
  wire payload    = !fifo_fbit;
  wire active     = (const_act_r || (left_r != 10'h000)) && (rate_act_r != 4'h0);
  wire count_en   = bit_move && payload && chan_sel && active;
  logic last_bit;

  pei_interval u_ivl (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .ce        (ce),
    .rate_code (rate_act_r),
    .count_en  (count_en),
    .last_bit  (last_bit)
  );

  wire do_err = last_bit;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bit_idx_r <= 3'h0;
      chan_r    <= 5'h00;
    end else if (bit_move) begin
      if (fifo_fbit) begin
        bit_idx_r <= 3'h0;
        chan_r    <= 5'h00;
      end else begin
        bit_idx_r <= bit_idx_r + 3'h1;
        if (bit_idx_r == 3'h7 && chan_r != 5'(PEI_CHANNELS - 1)) begin
          chan_r <= chan_r + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      out_valid_r <= 1'b0;
      out_data_r  <= 1'b0;
      out_fbit_r  <= 1'b0;
    end else if (ce && stage_free) begin
      out_valid_r <= fifo_valid;
      out_data_r  <= fifo_data ^ do_err;
      out_fbit_r  <= fifo_fbit;
    end
  end

  // rate and mode latched only on the framing bit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rate_act_r  <= 4'h0;
      const_act_r <= 1'b0;
    end else if (bit_move && fifo_fbit) begin
      rate_act_r  <= ctrl_r[PEI_CTRL_RATE_LSB +: 4];
      const_act_r <= ctrl_r[PEI_CTRL_CONST];
    end
  end

  // remaining count; load wins over a same-cycle decrement
  always_comb begin
    left_nxt = left_r;
    if (do_err && !const_act_r && left_r != 10'h000) begin
      left_nxt = left_r - 10'h001;
    end
    if (load_pend_r) begin
      left_nxt = {cnt_hi_r, cnt_lo_r};
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      load_prev_r <= 1'b0;
      load_pend_r <= 1'b0;
      left_r      <= PEI_RST_COUNT;
    end else if (ce) begin
      load_prev_r <= load_bit;
      load_pend_r <= load_rise;
      left_r      <= left_nxt;
    end
  end
endmodule

// ===== hw/pei_pkg.sv
package pei_pkg;
  // register offsets
  localparam logic [7:0] PEI_ADDR_CTRL     = 8'hEB;
  localparam logic [7:0] PEI_ADDR_CNT_LO   = 8'hEC;
  localparam logic [7:0] PEI_ADDR_CNT_HI   = 8'hED;
  localparam logic [7:0] PEI_ADDR_LEFT_LO  = 8'hEE;
  localparam logic [7:0] PEI_ADDR_LEFT_HI  = 8'hEF;
  localparam logic [7:0] PEI_ADDR_CHMASK0  = 8'hF0;
  localparam logic [7:0] PEI_ADDR_CHMASK1  = 8'hF1;
  localparam logic [7:0] PEI_ADDR_CHMASK2  = 8'hF2;
  // insertion_control fields
  localparam int PEI_CTRL_RATE_LSB = 0;
  localparam int PEI_CTRL_CONST    = 4;
  localparam int PEI_CTRL_LOAD     = 7;
  localparam logic [7:0] PEI_CTRL_WMASK = 8'h9F;
  // reset values
  localparam logic [7:0]  PEI_RST_BYTE   = 8'h00;
  localparam logic [9:0]  PEI_RST_COUNT  = 10'h000;
  localparam logic [23:0] PEI_RST_CHMASK = 24'hFFFFFF;
  // framing
  localparam int PEI_CH_BITS    = 8;
  localparam int PEI_CHANNELS   = 24;
  localparam int PEI_RATE_SHIFT = 3;
  localparam int PEI_IVL_W      = 18;
  localparam int PEI_FIFO_DEPTH = 16;
endpackage

// ===== hw/pei_fifo.sv
`timescale 1ns/100ps
module pei_fifo
  import pei_pkg::*;
#(
  parameter int WIDTH = 2,
  parameter int DEPTH = PEI_FIFO_DEPTH
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  wire              full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                            (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire              empty = (wr_ptr_r == rd_ptr_r);
  wire              push  = ce && in_valid && !full;
  wire              pop   = ce && out_ready && !empty;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_r[AW-1:0]];
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)  rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule

// ===== hw/pei_interval.sv
`timescale 1ns/100ps
module pei_interval
  import pei_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic [3:0] rate_code,
  input  wire logic       count_en,
  output logic            last_bit
);
  logic [PEI_IVL_W-1:0] cnt_r;
  logic [PEI_IVL_W-1:0] cnt_cur;
  logic [PEI_IVL_W-1:0] limit;
  logic [3:0]           rate_prev_r;
  // a new rate restarts the interval, so a shorter one never waits for a wrap
  wire                  restart = (rate_code != rate_prev_r);
  assign cnt_cur  = restart ? '0 : cnt_r;
  // code n gives an interval of 2^(n+3) bits
  assign limit    = (rate_code == 4'h0) ? '0 :
                    PEI_IVL_W'((1 << (rate_code + PEI_RATE_SHIFT)) - 1);
  assign last_bit = count_en && (rate_code != 4'h0) && (cnt_cur == limit);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_r       <= '0;
      rate_prev_r <= 4'h0;
    end else if (ce) begin
      rate_prev_r <= rate_code;
      if (count_en) begin
        cnt_r <= last_bit ? '0 : cnt_cur + 1'b1;
      end else if (restart) begin
        cnt_r <= '0;
      end
    end
  end
endmodule

// ===== test/pei_top_asserts.sv
`timescale 1ns/100ps
module pei_top_asserts
  import pei_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       out_valid,
  input wire logic       out_ready,
  input wire logic       out_data,
  input wire logic       out_fbit
);
  wire rd_ctl = reg_rd && reg_addr == PEI_ADDR_CTRL;
  wire rd_lo  = reg_rd && reg_addr == PEI_ADDR_CNT_LO;
  wire rd_hi  = reg_rd && (reg_addr == PEI_ADDR_CNT_HI || reg_addr == PEI_ADDR_LEFT_HI);
  wire wr_ctl = reg_wr && reg_addr == PEI_ADDR_CTRL;
  wire wr_lo  = reg_wr && reg_addr == PEI_ADDR_CNT_LO;
  wire stall  = out_valid && !out_ready;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_CTL_RSVD: assert property (rd_ctl |=> reg_rdata[6:5] == 2'h0)
    else $error("control bits 5 or 6 set");
  AST_HI_BITS: assert property (rd_hi |=> reg_rdata[7:2] == 6'h00)
    else $error("high count byte wider than 2 bits");
  AST_UNMAPPED: assert property (reg_rd && reg_addr < PEI_ADDR_CTRL |=>
    reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CNT_BACK: assert property (wr_lo ##1 !reg_wr ##1 rd_lo |=>
    reg_rdata == $past(reg_wdata, 3))
    else $error("count low readback wrong");
  AST_CTL_BACK: assert property (wr_ctl ##1 !reg_wr ##1 rd_ctl |=>
    reg_rdata == ($past(reg_wdata, 3) & PEI_CTRL_WMASK))
    else $error("control readback wrong");
  AST_OUT_HOLD: assert property (stall |=>
    out_valid && $stable({out_data, out_fbit}))
    else $error("output changed while stalled");
  AST_FLOW: assert property (tx_valid && tx_ready |-> ##[1:60] out_valid)
    else $error("accepted bit never reached output");
  cover property (stall);
  cover property (out_valid && out_ready && out_fbit);
  cover property (rd_hi ##1 reg_rdata != 8'h00);
endmodule
bind pei_top pei_top_asserts u_chk (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .tx_valid, .tx_ready, .out_valid, .out_ready, .out_data, .out_fbit);

// ===== test/pei_tx_model.sv
`timescale 1ns/100ps
module pei_tx_model (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic hold,
  input  wire logic tx_ready,
  output logic      tx_valid,
  output logic      tx_data,
  output logic      tx_fbit,
  input  wire logic out_valid,
  output logic      out_ready,
  input  wire logic out_data,
  input  wire logic out_fbit,
  output int        n_err,
  output int        gap,
  output int        frames,
  output logic      f_bad
);
  int b, since, cyc;
  // framing bit sent as one, payload as zero: a set payload bit is an error
  assign tx_valid  = resetn;
  assign tx_fbit   = (b == 0);
  assign tx_data   = tx_fbit;
  // stall one cycle in five, fully while hold
  assign out_ready = !hold && (cyc % 5 != 0);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {b, since, cyc, n_err, gap, frames} <= '0;
      f_bad <= 1'b0;
    end else begin
      cyc <= cyc + 1;
      if (tx_valid && tx_ready) b <= (b == 192) ? 0 : b + 1;
      if (out_valid && out_ready && out_fbit) begin
        frames <= frames + 1;
        f_bad <= f_bad | !out_data;
      end
      if (out_valid && out_ready && !out_fbit) begin
        since <= out_data ? 0 : since + 1;
        if (out_data) begin
          n_err <= n_err + 1;
          gap <= since + 1;
        end
      end
    end
  end
endmodule

// ===== test/payload_error_inserter_test.sv
`timescale 1ns/100ps
module payload_error_inserter_test
  import pei_pkg::*;
;
  logic       clk_sys, resetn, reg_wr, reg_rd, hold, tx_valid, tx_ready, tx_data, tx_fbit;
  logic       out_valid, out_ready, out_data, out_fbit, f_bad;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int         n_err, gap, frames, n_errors, check_count, n0;
  pei_top dut (.clk_sys, .resetn, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .tx_valid, .tx_ready, .tx_data, .tx_fbit, .out_valid, .out_ready,
    .out_data, .out_fbit);
  pei_tx_model far (.clk_sys, .resetn, .hold, .tx_ready, .tx_valid, .tx_data, .tx_fbit,
    .out_valid, .out_ready, .out_data, .out_fbit, .n_err, .gap, .frames, .f_bad);
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", 16'(e), 16'(reg_rdata));
  endtask
  task automatic wf(input int n);
    int f0;
    f0 = frames;
    while (frames < f0 + n) @(posedge clk_sys);
  endtask
  // skip two frames: the frame in flight may still carry the old setting
  task automatic run(input int n);
    wf(2);
    n0 = n_err;
    wf(n);
  endtask
  task automatic t_regs;
    for (int a = 0; a < 5; a++) rd(8'(PEI_ADDR_CTRL + a), 8'h00);
    rd(8'h10, 8'h00);
    wr(PEI_ADDR_CTRL, 8'h9F);
    rd(PEI_ADDR_CTRL, 8'h9F);
    wr(PEI_ADDR_CTRL, 8'h00);
    wr(PEI_ADDR_CNT_LO, 8'hA5);
    rd(PEI_ADDR_CNT_LO, 8'hA5);
    wr(PEI_ADDR_CNT_HI, 8'hFF);
    rd(PEI_ADDR_CNT_HI, 8'h03);
  endtask
  task automatic t_counted;
    hold <= 1'b1;
    wr(PEI_ADDR_CTRL, 8'h01);
    wr(PEI_ADDR_CNT_LO, 8'h05);
    wr(PEI_ADDR_CNT_HI, 8'h01);
    wr(PEI_ADDR_CTRL, 8'h81);
    repeat (20) @(posedge clk_sys);
    chk("tx_ready", 16'h0, 16'(tx_ready));
    rd(PEI_ADDR_LEFT_LO, 8'h05);
    rd(PEI_ADDR_LEFT_HI, 8'h01);
    n0 = n_err;
    hold <= 1'b0;
    wf(26);
    chk("errors", 16'd261, 16'(n_err - n0));
    chk("gap", 16'd16, 16'(gap));
    rd(PEI_ADDR_LEFT_LO, 8'h00);
    wr(PEI_ADDR_CNT_LO, 8'h02);
    wr(PEI_ADDR_CTRL, 8'h81);
    // give a wrongful load time to reach the remaining count
    repeat (3) @(posedge clk_sys);
    rd(PEI_ADDR_LEFT_LO, 8'h00);
  endtask
  task automatic t_rates;
    for (int c = 1; c < 5; c++) begin
      wr(PEI_ADDR_CTRL, 8'(8'h10 + c));
      run(3);
      chk("gap", 16'(1 << (c + 3)), 16'(gap));
      chk("const", 16'h1, 16'(n_err > n0));
    end
  endtask
  task automatic t_off;
    wr(PEI_ADDR_CTRL, 8'h10);
    run(2);
    chk("rate0", 16'h0, 16'(n_err - n0));
    wr(PEI_ADDR_CHMASK1, 8'h00);
    wr(PEI_ADDR_CHMASK2, 8'h00);
    wr(PEI_ADDR_CHMASK0, 8'h01);
    wr(PEI_ADDR_CTRL, 8'h11);
    run(5);
    chk("ch0 gap", 16'd384, 16'(gap));
    wr(PEI_ADDR_CHMASK0, 8'h00);
    run(2);
    chk("no chan", 16'h0, 16'(n_err - n0));
    chk("fbit", 16'h0, 16'(f_bad));
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #400000;
    n_errors++;
    complete_run();
  end
  initial begin
    {resetn, reg_wr, reg_rd, hold, reg_addr, reg_wdata} = '0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    t_regs();
    t_counted();
    t_rates();
    t_off();
    complete_run();
  end
endmodule
